/* File: verilog/tcc_top.sv */
// Timer capture channels, control registers and compare output latches
`timescale 1ns/10ps
// ----------------------------------------------------------------
// Summary of operation
// R1 - Each channel copies the counter into its 16-bit capture register on edge
// R2 - Edge-select one picks rising edges, zero picks falling edges
// R3 - Capture raises interrupt request only with its enable set
// R4 - Captured value is counter before the transition plus one
// R5 - Counter advances once every four bus clocks
// R6 - Capture happens whether or not the capture flag is set
// R7 - High byte read blocks captures until low byte is read
// R8 - Low byte read alone never blocks captures
// R9 - Reset leaves capture register contents untouched
// R10 - Interrupt control holds five enables and shut-off, all clear on reset
// R11 - Shut-off bit one stops the timer, zero lets it run
// R12 - Compare-2-drives-latch-1 loads level 2 into latch 1 on compare 2
// R13 - Compare-1-drives-latch-2 loads level 1 into latch 2 on compare 1
// R14 - Force strobes read zero; writing zero does nothing
// R15 - Writing one to a force strobe copies level into its latch
// R16 - Forced update leaves the compare flag unchanged
// R17 - Level bit goes to its latch on next compare match
// R18 - Capture flag set by edge, cleared by status read then low read
// R19 - Compare match sets compare flag and drives level onto pin
// R20 - Interrupt control bits two and one read zero, writes ignored
// ----------------------------------------------------------------

// ----------------------------------------------------------------
// Capture channel
// ----------------------------------------------------------------
module tcc_capture (
    input  wire logic        mclk,
    input  wire logic        rst,
    input  wire logic        pin,
    input  wire logic        rise_sel,
    input  wire logic [15:0] count,
    input  wire logic        read_high,
    input  wire logic        read_low,
    input  wire logic        status_read,
    output logic [15:0]      value,
    output logic             flag
);
    logic pin_prev;
    logic hold;
    logic armed;

    // Pins come in clock-synchronous, so one sample stage is enough
    wire  rise       = pin & ~pin_prev;
    wire  fall       = ~pin & pin_prev;
    wire  edge_seen  = rise_sel ? rise : fall;                    // R2
    wire  flag_clear = read_low & armed;
    wire  next_flag  = edge_seen | (flag & ~flag_clear);          // R18

    // Data register has no reset on purpose
    always_ff @(posedge mclk) begin
        if (edge_seen && !hold) begin                             // R1 R6 R7 R9
            value <= 16'(count + 16'h0001);                       // R4
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            pin_prev <= 1'b0;
            hold     <= 1'b0;
            armed    <= 1'b0;
            flag     <= 1'b0;
        end else begin
            pin_prev <= pin;
            hold     <= read_low ? 1'b0 : (read_high | hold);     // R7 R8
            armed    <= status_read ? flag : (armed & ~read_low);
            flag     <= next_flag;
        end
    end
endmodule

// ----------------------------------------------------------------
// Top level
// ----------------------------------------------------------------
module tcc_top import tcc_pkg::*; (
    input  wire logic            mclk,
    input  wire logic            rst,
    input  wire tcc_axi_req_type axi_req,
    output tcc_axi_rsp_type      axi_rsp,
    input  wire logic            capture_pin_1,
    input  wire logic            capture_pin_2,
    input  wire logic            compare1_match,
    input  wire logic            compare2_match,
    input  wire logic            compare1_low_access,
    input  wire logic            compare2_low_access,
    output logic                 compare_pin_1,
    output logic                 compare_pin_2,
    output logic [15:0]          timer_count,
    output logic                 irq_request
);
    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    logic [7:0]  int_ctrl;
    logic [7:0]  edge_out;
    logic [1:0]  prescale;
    logic        aw_held;
    logic [7:0]  aw_addr;
    logic        w_held;
    logic [31:0] w_data;
    logic [3:0]  w_strb;
    logic        compare1_flag;
    logic        compare2_flag;
    logic        cmp1_armed;
    logic        cmp2_armed;
    logic [15:0] cap1_value;
    logic [15:0] cap2_value;
    logic        capture1_flag;
    logic        capture2_flag;
    logic        aw_ready;
    logic        w_ready;
    logic        b_valid;
    logic [1:0]  b_resp;
    logic        ar_ready;
    logic        r_valid;
    logic [31:0] r_data;
    logic [1:0]  r_resp;

    // ------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------
    wire        aw_take    = axi_req.awvalid & axi_rsp.awready;
    wire        w_take     = axi_req.wvalid & axi_rsp.wready;
    wire        do_write   = aw_held & w_held & ~axi_rsp.bvalid;
    wire        next_aw    = do_write ? 1'b0 : (aw_held | aw_take);
    wire        next_w     = do_write ? 1'b0 : (w_held | w_take);
    wire        next_bv    = do_write | (axi_rsp.bvalid & ~axi_req.bready);
    wire [5:0]  w_idx      = aw_addr[7:2];
    wire        wr_byte    = do_write & w_strb[0];
    wire        wr_int     = wr_byte & (w_idx == IDX_INT_CTRL);
    wire        wr_edge    = wr_byte & (w_idx == IDX_EDGE_OUT);

    wire        ar_take    = axi_req.arvalid & axi_rsp.arready;
    wire        next_rv    = ar_take | (axi_rsp.rvalid & ~axi_req.rready);
    wire [5:0]  r_idx      = axi_req.araddr[7:2];
    wire        rd_c1_high = ar_take & (r_idx == IDX_CAP1_HIGH);
    wire        rd_c1_low  = ar_take & (r_idx == IDX_CAP1_LOW);
    wire        rd_c2_high = ar_take & (r_idx == IDX_CAP2_HIGH);
    wire        rd_c2_low  = ar_take & (r_idx == IDX_CAP2_LOW);
    wire        rd_flags   = ar_take & (r_idx == IDX_FLAGS);

    function automatic logic mapped(input logic [5:0] idx);
        mapped = (idx == IDX_CAP1_HIGH) || (idx == IDX_CAP1_LOW) ||
                 (idx == IDX_CAP2_HIGH) || (idx == IDX_CAP2_LOW) ||
                 (idx == IDX_INT_CTRL)  || (idx == IDX_EDGE_OUT) ||
                 (idx == IDX_FLAGS);
    endfunction

    wire [7:0] flag_bits = (8'(capture1_flag) << CAP1_F_BIT) |
                           (8'(capture2_flag) << CAP2_F_BIT) |
                           (8'(compare1_flag) << CMP1_F_BIT) |
                           (8'(compare2_flag) << CMP2_F_BIT);

    // Force strobes never stored, so they read zero
    wire [7:0] read_byte =
        (r_idx == IDX_CAP1_HIGH) ? cap1_value[15:8] :
        (r_idx == IDX_CAP1_LOW)  ? cap1_value[7:0]  :
        (r_idx == IDX_CAP2_HIGH) ? cap2_value[15:8] :
        (r_idx == IDX_CAP2_LOW)  ? cap2_value[7:0]  :
        (r_idx == IDX_INT_CTRL)  ? int_ctrl         :           // R20
        (r_idx == IDX_EDGE_OUT)  ? edge_out         :           // R14
        (r_idx == IDX_FLAGS)     ? flag_bits        : 8'h00;

    // ------------------------------------------------------------
    // Bus answer
    // ------------------------------------------------------------
    // One driver for the whole answer; each channel keeps its own flops
    assign axi_rsp = '{
        awready : aw_ready,
        wready  : w_ready,
        bvalid  : b_valid,
        bresp   : b_resp,
        arready : ar_ready,
        rvalid  : r_valid,
        rdata   : r_data,
        rresp   : r_resp
    };

    // ------------------------------------------------------------
    // Counter
    // ------------------------------------------------------------
    wire timer_run  = ~int_ctrl[SHUTOFF_BIT];                     // R11
    wire count_tick = timer_run & (prescale == PRESCALE_LAST);    // R5

    // Prescaler keeps its phase while shut off
    always_ff @(posedge mclk) begin
        if (rst) begin
            prescale    <= 2'h0;
            timer_count <= COUNT_RST;
        end else begin
            if (timer_run) begin
                prescale <= 2'(prescale + 2'h1);
            end
            if (count_tick) begin
                timer_count <= 16'(timer_count + 16'h0001);       // R5
            end
        end
    end

    // ------------------------------------------------------------
    // Output latches
    // ------------------------------------------------------------
    wire force1   = wr_edge & w_data[FORCE1_BIT];                 // R14 R15
    wire force2   = wr_edge & w_data[FORCE2_BIT];                 // R14 R15
    wire level1   = edge_out[LEVEL1_BIT];
    wire level2   = edge_out[LEVEL2_BIT];
    wire c2_to_l1 = compare2_match & edge_out[C2L1_BIT];          // R12
    wire c1_to_l2 = compare1_match & edge_out[C1L2_BIT];          // R13

    // Own compare outranks the cross-clocked one
    wire next_pin1 = force1         ? w_data[LEVEL1_BIT] :        // R15
                     compare1_match ? level1 :                    // R17 R19
                     c2_to_l1       ? level2 : compare_pin_1;     // R12
    wire next_pin2 = force2         ? w_data[LEVEL2_BIT] :        // R15
                     compare2_match ? level2 :                    // R17 R19
                     c1_to_l2       ? level1 : compare_pin_2;     // R13

    // Flags ignore force writes; only matches set them
    wire cmp1_clear = compare1_low_access & cmp1_armed;
    wire cmp2_clear = compare2_low_access & cmp2_armed;
    wire next_cf1   = compare1_match | (compare1_flag & ~cmp1_clear); // R16 R19
    wire next_cf2   = compare2_match | (compare2_flag & ~cmp2_clear); // R16 R19

    wire next_irq = (capture1_flag & int_ctrl[CAP1_IE_BIT]) |     // R3
                    (capture2_flag & int_ctrl[CAP2_IE_BIT]) |     // R3
                    (compare1_flag & int_ctrl[CMP1_IE_BIT]) |
                    (compare2_flag & int_ctrl[CMP2_IE_BIT]);

    // ------------------------------------------------------------
    // Capture channels
    // ------------------------------------------------------------
    tcc_capture u_cap1 (
        .mclk        (mclk),
        .rst         (rst),
        .pin         (capture_pin_1),
        .rise_sel    (edge_out[EDGE1_BIT]),
        .count       (timer_count),
        .read_high   (rd_c1_high),
        .read_low    (rd_c1_low),
        .status_read (rd_flags),
        .value       (cap1_value),
        .flag        (capture1_flag)
    );

    tcc_capture u_cap2 (
        .mclk        (mclk),
        .rst         (rst),
        .pin         (capture_pin_2),
        .rise_sel    (edge_out[EDGE2_BIT]),
        .count       (timer_count),
        .read_high   (rd_c2_high),
        .read_low    (rd_c2_low),
        .status_read (rd_flags),
        .value       (cap2_value),
        .flag        (capture2_flag)
    );

    // ------------------------------------------------------------
    // Write channel
    // ------------------------------------------------------------
    always_ff @(posedge mclk) begin
        if (rst) begin
            aw_held         <= 1'b0;
            w_held          <= 1'b0;
            aw_addr         <= 8'h00;
            w_data          <= 32'h0000_0000;
            w_strb          <= 4'h0;
            aw_ready        <= 1'b0;
            w_ready         <= 1'b0;
            b_valid         <= 1'b0;
            b_resp          <= RESP_OKAY;
        end else begin
            aw_held         <= next_aw;
            w_held          <= next_w;
            aw_ready        <= ~next_aw;
            w_ready         <= ~next_w;
            b_valid         <= next_bv;
            if (aw_take) begin
                aw_addr <= axi_req.awaddr;
            end
            if (w_take) begin
                w_data <= axi_req.wdata;
                w_strb <= axi_req.wstrb;
            end
            if (do_write) begin
                b_resp <= mapped(w_idx) ? RESP_OKAY : RESP_SLVERR;
            end
        end
    end

    // ------------------------------------------------------------
    // Read channel
    // ------------------------------------------------------------
    always_ff @(posedge mclk) begin
        if (rst) begin
            ar_ready <= 1'b0;
            r_valid  <= 1'b0;
            r_data   <= 32'h0000_0000;
            r_resp   <= RESP_OKAY;
        end else begin
            ar_ready <= ~next_rv;
            r_valid  <= next_rv;
            if (ar_take) begin
                r_data <= {24'h00_0000, read_byte};
                r_resp <= mapped(r_idx) ? RESP_OKAY : RESP_SLVERR;
            end
        end
    end

    // ------------------------------------------------------------
    // Control and outputs
    // ------------------------------------------------------------
    always_ff @(posedge mclk) begin
        if (rst) begin
            int_ctrl      <= INT_CTRL_RST;                        // R10
            edge_out      <= EDGE_OUT_RST;
            compare_pin_1 <= 1'b0;
            compare_pin_2 <= 1'b0;
            compare1_flag <= 1'b0;
            compare2_flag <= 1'b0;
            cmp1_armed    <= 1'b0;
            cmp2_armed    <= 1'b0;
            irq_request   <= 1'b0;
        end else begin
            if (wr_int) begin
                int_ctrl <= w_data[7:0] & INT_CTRL_MASK;          // R10 R20
            end
            if (wr_edge) begin
                edge_out <= w_data[7:0] & EDGE_OUT_MASK;          // R14
            end
            compare_pin_1 <= next_pin1;
            compare_pin_2 <= next_pin2;
            compare1_flag <= next_cf1;
            compare2_flag <= next_cf2;
            cmp1_armed    <= rd_flags ? compare1_flag : (cmp1_armed & ~compare1_low_access);
            cmp2_armed    <= rd_flags ? compare2_flag : (cmp2_armed & ~compare2_low_access);
            irq_request   <= next_irq;
        end
    end
endmodule

/* File: verilog/tcc_pkg.sv */
// Constants and bus types for the timer capture and control block
package tcc_pkg;
    // Register indices; byte address is four times the index
    localparam logic [5:0] IDX_CAP1_HIGH = 6'h10;
    localparam logic [5:0] IDX_CAP1_LOW  = 6'h11;
    localparam logic [5:0] IDX_CAP2_HIGH = 6'h14;
    localparam logic [5:0] IDX_CAP2_LOW  = 6'h15;
    localparam logic [5:0] IDX_INT_CTRL  = 6'h1c;
    localparam logic [5:0] IDX_EDGE_OUT  = 6'h1d;
    localparam logic [5:0] IDX_FLAGS     = 6'h1e;
    // timer_interrupt_control fields
    localparam int         CAP1_IE_BIT   = 7;
    localparam int         CAP2_IE_BIT   = 6;
    localparam int         CMP1_IE_BIT   = 5;
    localparam int         OVF_IE_BIT    = 4;
    localparam int         CMP2_IE_BIT   = 3;
    localparam int         SHUTOFF_BIT   = 0;
    localparam logic [7:0] INT_CTRL_MASK = 8'hf9;
    localparam logic [7:0] INT_CTRL_RST  = 8'h00;
    // timer_edge_output_control fields
    localparam int         EDGE1_BIT     = 7;
    localparam int         EDGE2_BIT     = 6;
    localparam int         C2L1_BIT      = 5;
    localparam int         FORCE1_BIT    = 4;
    localparam int         LEVEL1_BIT    = 3;
    localparam int         C1L2_BIT      = 2;
    localparam int         FORCE2_BIT    = 1;
    localparam int         LEVEL2_BIT    = 0;
    localparam logic [7:0] EDGE_OUT_MASK = 8'hed;
    localparam logic [7:0] EDGE_OUT_RST  = 8'h00;
    // timer_flag_register fields
    localparam int         CAP1_F_BIT    = 7;
    localparam int         CAP2_F_BIT    = 6;
    localparam int         CMP1_F_BIT    = 5;
    localparam int         CMP2_F_BIT    = 3;
    // Counter
    localparam logic [15:0] COUNT_RST     = 16'hfffc;
    localparam logic [1:0]  PRESCALE_LAST = 2'h3;
    // AXI answers
    localparam logic [1:0] RESP_OKAY     = 2'h0;
    localparam logic [1:0] RESP_SLVERR   = 2'h2;

    typedef struct packed {
        logic        awvalid;
        logic [7:0]  awaddr;
        logic        wvalid;
        logic [31:0] wdata;
        logic [3:0]  wstrb;
        logic        bready;
        logic        arvalid;
        logic [7:0]  araddr;
        logic        rready;
    } tcc_axi_req_type;

    typedef struct packed {
        logic        awready;
        logic        wready;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        arready;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
    } tcc_axi_rsp_type;
endpackage

/* File: bench/tcc_pin_model.sv */
// Far-side model of the capture pins driven by the bench
`timescale 1ns/10ps
module tcc_pin_model (
    input  wire logic       mclk,
    input  wire logic [1:0] want,
    output logic            capture_pin_1,
    output logic            capture_pin_2
);
    initial {capture_pin_2, capture_pin_1} = 2'h0;
    // Levels change only after an edge, as the block samples the pins directly
    always @(posedge mclk) begin
        capture_pin_1 <= want[0];
        capture_pin_2 <= want[1];
    end
endmodule

/* File: bench/tcc_top_sva.sv */
// Port-level concurrent checks for the timer capture and control block
`timescale 1ns/10ps
module tcc_sva import tcc_pkg::*; (
    input wire logic            mclk,
    input wire logic            rst,
    input wire tcc_axi_req_type axi_req,
    input wire tcc_axi_rsp_type axi_rsp,
    input wire logic            capture_pin_1,
    input wire logic            capture_pin_2,
    input wire logic            compare1_match,
    input wire logic            compare2_match,
    input wire logic            compare_pin_1,
    input wire logic            compare_pin_2,
    input wire logic [15:0]     timer_count,
    input wire logic            irq_request
);
    default clocking dc @(posedge mclk); endclocking
    default disable iff (rst);
    logic [1:0] pin_q;
    logic       bv_q;
    logic [7:0] ar_q;
    wire  [1:0] pins = {compare_pin_2, compare_pin_1};
    // Anything that may raise the request: pin change, match or register write
    wire        ev = (pin_q != {capture_pin_2, capture_pin_1}) | compare1_match
                   | compare2_match | (axi_rsp.bvalid & ~bv_q);
    always_ff @(posedge mclk) begin
        pin_q <= {capture_pin_2, capture_pin_1};
        bv_q  <= axi_rsp.bvalid;
        if (axi_req.arvalid && axi_rsp.arready) begin
            ar_q <= axi_req.araddr;
        end
    end
    sequence s_rd_take; axi_req.arvalid && axi_rsp.arready; endsequence
    sequence s_wr_take; axi_req.awvalid && axi_rsp.awready && axi_req.wvalid && axi_rsp.wready;
    endsequence
    sequence s_read_of(logic [7:0] a); axi_rsp.rvalid && ar_q == a; endsequence
    property p_rd_answer; s_rd_take |=> axi_rsp.rvalid; endproperty
    a_rd_answer: assert property (p_rd_answer)
        else $error("read answer late");
    property p_wr_answer; s_wr_take |-> ##[1:2] axi_rsp.bvalid; endproperty
    a_wr_answer: assert property (p_wr_answer)
        else $error("write answer late");
    property p_cnt_step; $changed(timer_count) |-> timer_count == $past(timer_count) + 16'h1;
    endproperty
    a_cnt_step: assert property (p_cnt_step)
        else $error("counter skipped");
    property p_cnt_hold; $changed(timer_count) |=> $stable(timer_count) [*3]; endproperty
    a_cnt_hold: assert property (p_cnt_hold)
        else $error("counter ticks too fast");
    property p_pin_cause;
        $changed(pins) |-> $past(compare1_match || compare2_match) || $rose(axi_rsp.bvalid);
    endproperty
    a_pin_cause: assert property (p_pin_cause)
        else $error("compare pin moved without cause");
    property p_irq_cause; $rose(irq_request) |-> $past(ev) || $past(ev, 2) || $past(ev, 3);
    endproperty
    a_irq_cause: assert property (p_irq_cause)
        else $error("request rose without cause");
    property p_strobe_zero;
        s_read_of({IDX_EDGE_OUT, 2'h0}) |-> axi_rsp.rdata[FORCE1_BIT] == 1'b0
            && axi_rsp.rdata[FORCE2_BIT] == 1'b0;
    endproperty
    a_strobe_zero: assert property (p_strobe_zero)
        else $error("strobe read back set");
    property p_unused_zero; s_read_of({IDX_INT_CTRL, 2'h0}) |-> axi_rsp.rdata[2:1] == 2'h0;
    endproperty
    a_unused_zero: assert property (p_unused_zero)
        else $error("unused bits read set");
    property p_upper_zero; axi_rsp.rvalid |-> axi_rsp.rdata[31:8] == 24'h0; endproperty
    a_upper_zero: assert property (p_upper_zero)
        else $error("upper read bits set");
endmodule
bind tcc_top tcc_sva tcc_sva_inst (.mclk(mclk), .rst(rst), .axi_req(axi_req),
    .axi_rsp(axi_rsp), .capture_pin_1(capture_pin_1), .capture_pin_2(capture_pin_2),
    .compare1_match(compare1_match), .compare2_match(compare2_match),
    .compare_pin_1(compare_pin_1), .compare_pin_2(compare_pin_2),
    .timer_count(timer_count), .irq_request(irq_request));

/* File: bench/tb.sv */
// Self-checking bench for the timer capture and control block
`timescale 1ns/10ps
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin num_errors++; \
    $display("CHECK FAILED %s exp %0h got %0h", n, e, g); end end
module tb import tcc_pkg::*; ();
    logic            mclk = 1'b0;
    logic            rst = 1'b1;
    tcc_axi_req_type req = '0;
    tcc_axi_rsp_type rsp;
    logic [1:0]      want = 2'h0;
    logic [1:0]      cmp = 2'h0;
    logic [1:0]      low_access = 2'h0;
    logic            capture_pin_1, capture_pin_2, compare_pin_1, compare_pin_2, irq_request;
    logic [15:0]     timer_count;
    logic [1:0]      rr;
    wire  [1:0]      pins = {compare_pin_2, compare_pin_1};
    int              num_errors = 0;
    int              comparisons = 0;
    always #10 mclk = ~mclk;
    tcc_top tcc_top_inst (.mclk(mclk), .rst(rst), .axi_req(req), .axi_rsp(rsp),
        .capture_pin_1(capture_pin_1), .capture_pin_2(capture_pin_2),
        .compare1_match(cmp[0]), .compare2_match(cmp[1]),
        .compare1_low_access(low_access[0]), .compare2_low_access(low_access[1]),
        .compare_pin_1(compare_pin_1), .compare_pin_2(compare_pin_2),
        .timer_count(timer_count), .irq_request(irq_request));
    tcc_pin_model tcc_pin_model_inst (.mclk(mclk), .want(want),
        .capture_pin_1(capture_pin_1), .capture_pin_2(capture_pin_2));
    // Bready and rready stay high, so every answer is taken where it appears
    task automatic wr(input logic [5:0] i, input logic [7:0] d);
        req.awvalid <= 1'b1;
        req.awaddr  <= {i, 2'h0};
        req.wvalid  <= 1'b1;
        req.wdata   <= {24'h0, d};
        do begin
            @(posedge mclk);
            if (rsp.awready) req.awvalid <= 1'b0;
            if (rsp.wready) req.wvalid <= 1'b0;
        end while (!rsp.bvalid);
        rr = rsp.bresp;
        @(posedge mclk);
    endtask
    task automatic rd(input logic [5:0] i, output logic [7:0] d);
        req.arvalid <= 1'b1;
        req.araddr  <= {i, 2'h0};
        do begin
            @(posedge mclk);
            if (rsp.arready) req.arvalid <= 1'b0;
        end while (!rsp.rvalid);
        d = rsp.rdata[7:0];
        rr = rsp.rresp;
    endtask
    // Pin moves one edge later; the count seen just before the sampling edge plus one
    task automatic ev(input int ch, input logic v, output logic [15:0] e);
        want[ch] <= v;
        @(posedge mclk);
        @(negedge mclk);
        e = timer_count + 16'h1;
        repeat (3) @(posedge mclk);
    endtask
    task automatic cap(input int ch, output logic [15:0] v);
        rd(ch ? IDX_CAP2_HIGH : IDX_CAP1_HIGH, v[15:8]);
        rd(ch ? IDX_CAP2_LOW : IDX_CAP1_LOW, v[7:0]);
    endtask
    task automatic pm(input int ch);
        cmp[ch] <= 1'b1;
        @(posedge mclk);
        cmp[ch] <= 1'b0;
        repeat (2) @(posedge mclk);
    endtask
    task tally_and_finish;
        $display("Comparisons %0d mismatches %0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    initial begin
        repeat (5000) @(posedge mclk);
        num_errors++;
        tally_and_finish;
    end
    // ----------
    // Tests
    // ----------
    initial begin
        logic [7:0]  d;
        logic [15:0] x, ex, old;
        req.bready = 1'b1;
        req.rready = 1'b1;
        req.wstrb = 4'hf;
        repeat (8) @(posedge mclk);
        rst <= 1'b0;
        @(posedge mclk);
        rd(IDX_INT_CTRL, d);
        `CHK("int ctrl reset", INT_CTRL_RST, d)
        wr(IDX_INT_CTRL, 8'hff);
        rd(IDX_INT_CTRL, d);
        `CHK("int ctrl bits", INT_CTRL_MASK, d)
        x = timer_count;
        repeat (12) @(posedge mclk);
        `CHK("count frozen", x, timer_count)
        wr(IDX_INT_CTRL, 8'h00);
        repeat (8) @(posedge mclk);
        `CHK("count runs", 1'b1, timer_count !== x)
        rd(6'h00, d);
        `CHK("unmapped read", RESP_SLVERR, rr)
        wr(IDX_CAP1_HIGH, 8'h55);
        `CHK("read-only write", RESP_OKAY, rr)
        $display("Test registers done");
        for (int ch = 0; ch < 2; ch++) begin
            for (int e = 0; e < 2; e++) begin
                wr(IDX_EDGE_OUT, e ? (ch ? 8'h40 : 8'h80) : 8'h00);
                ev(ch, 1'b1, x);
                if (e) ex = x;
                ev(ch, 1'b0, x);
                if (!e) ex = x;
                rd(IDX_FLAGS, d);
                `CHK("capture flag", 1'b1, d[7 - ch])
                cap(ch, x);
                `CHK("capture value", ex, x)
            end
        end
        wr(IDX_EDGE_OUT, 8'h80);
        ev(0, 1'b1, ex);
        `CHK("request masked", 1'b0, irq_request)
        wr(IDX_INT_CTRL, 8'h80);
        repeat (2) @(posedge mclk);
        `CHK("request raised", 1'b1, irq_request)
        rd(IDX_FLAGS, d);
        rd(IDX_CAP1_LOW, d);
        rd(IDX_FLAGS, d);
        `CHK("flag cleared", 1'b0, d[CAP1_F_BIT])
        repeat (2) @(posedge mclk);
        `CHK("request dropped", 1'b0, irq_request)
        $display("Test capture done");
        cap(0, old);
        ev(0, 1'b0, x);
        rd(IDX_CAP1_HIGH, d);
        ev(0, 1'b1, x);
        rd(IDX_CAP1_LOW, d);
        `CHK("blocked low byte", old[7:0], d)
        cap(0, x);
        `CHK("blocked value", old, x)
        rd(IDX_CAP1_LOW, d);
        ev(0, 1'b0, x);
        ev(0, 1'b1, ex);
        cap(0, x);
        `CHK("unblocked value", ex, x)
        ev(0, 1'b0, x);
        rst <= 1'b1;
        repeat (2) @(posedge mclk);
        rst <= 1'b0;
        @(posedge mclk);
        cap(0, x);
        `CHK("kept over reset", ex, x)
        $display("Test blocking done");
        wr(IDX_EDGE_OUT, 8'h08);
        `CHK("level waits", 1'b0, compare_pin_1)
        pm(0);
        rd(IDX_FLAGS, d);
        `CHK("match pins", 2'h1, pins)
        `CHK("match flag", 1'b1, d[CMP1_F_BIT])
        wr(IDX_EDGE_OUT, 8'h12);
        `CHK("forced low", 2'h0, pins)
        rd(IDX_FLAGS, d);
        `CHK("flag kept", 1'b1, d[CMP1_F_BIT])
        low_access[0] <= 1'b1;
        @(posedge mclk);
        low_access[0] <= 1'b0;
        rd(IDX_FLAGS, d);
        `CHK("compare flag cleared", 1'b0, d[CMP1_F_BIT])
        wr(IDX_EDGE_OUT, 8'h09);
        `CHK("zero strobe", 2'h0, pins)
        wr(IDX_EDGE_OUT, 8'h1b);
        rd(IDX_EDGE_OUT, d);
        `CHK("strobe readback", 8'h09, d)
        `CHK("forced high", 2'h3, pins)
        wr(IDX_EDGE_OUT, 8'h20);
        pm(1);
        `CHK("compare 2 to latch 1", 2'h0, pins)
        wr(IDX_EDGE_OUT, 8'h0c);
        pm(0);
        `CHK("compare 1 to latch 2", 2'h3, pins)
        $display("Test compare done");
        tally_and_finish;
    end
endmodule
